// file: rbcp_host.sv
// host side model that collects reply bytes, optionally stalling
`default_nettype none
module rbcp_host (
   input wire logic clk_in, // clock
   input wire logic nrst_in, // reset, active low
   input wire logic slow_in, // stall the reply sink
   input wire rbcp_pkg::rbcp_byte_t tx_in, // reply bytes
   output logic ready_out // sink takes a byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   logic [7:0] got[$];
   // one byte in four cycles when slow, so held reply bytes get exercised
   assign ready_out = !slow_in || cnt == 2'h0;
   always @(posedge clk_in) begin
      if (!nrst_in) cnt <= 2'h0;
      else cnt <= cnt + 2'h1;
      if (nrst_in && tx_in.valid && ready_out) got.push_back(tx_in.data);
   end
endmodule
`default_nettype wire

// file: rbcp_parser.sv
// relay bank command parser with device selection, banking and refresh
//
// Our own choices: the register offsets and register access over AHB-Lite.
`default_nettype none
// What this block does
// - byte 254 is the prefix; the next byte is the command code.
// - with reporting on, accepted ordinary commands answer with byte 85.
// - device selection commands never send an acknowledge byte.
// - enabled after reset; selection commands always run, others ignored when disabled.
// - code 248 enables every unit.
// - code 249 disables every unit.
// - code 250 plus number enables the matching unit, others unchanged.
// - code 251 plus number disables the matching unit, others unchanged.
// - code 252 plus number enables the match and disables all others.
// - code 253 plus number disables the match and enables all others.
// - code 246 returns id part one, id part two, firmware, year minus 1800.
// - code 247 returns the stored device number.
// - a stored device number acts at once, enable state untouched.
// - storing a device number works only in configuration mode.
// - configuration mode is entered when all option switches are off at reset.
// - relays form 32 banks of 8, banks addressed 1 to 32.
// - bank 0 addresses relay n in every bank at once.
// - bank directed commands use the last selected bank.
// - bank specified commands use the bank byte they carry.
// - with auto refresh on, relay commands update the outputs directly.
// - with auto refresh off, relay commands change only the image memory.
// - manual refresh copies the whole image to all outputs at once.

module rbcp_parser #(
   parameter int NUM_SWITCHES = 8,
   parameter logic [7:0] DEVNUM_RESET = 8'h00,
   parameter logic [7:0] ID_PART1 = 8'hA5, // arbitrary value
   parameter logic [7:0] ID_PART2 = 8'h5A, // arbitrary value
   parameter logic [7:0] FW_VERSION = 8'h01,
   parameter int PROD_YEAR = 2024
) (
   input wire logic core_clk_in, // system clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic [NUM_SWITCHES-1:0] option_sw_in, // option switch pins
   input wire rbcp_pkg::rbcp_byte_t rx_in, // received byte stream
   output rbcp_pkg::rbcp_byte_t tx_out, // reply byte stream
   input wire logic tx_ready_in, // reply sink takes byte
   output logic rx_ready_out, // parser takes a byte
   output logic [255:0] relay_out, // physical relay drive
   input wire logic hsel_in, // ahb slave select
   input wire logic [31:0] haddr_in, // ahb address
   input wire logic [1:0] htrans_in, // ahb transfer type
   input wire logic hwrite_in, // ahb write
   input wire logic [2:0] hsize_in, // ahb size
   input wire logic [31:0] hwdata_in, // ahb write data
   input wire logic hready_in, // ahb bus ready
   output logic [31:0] hrdata_out, // ahb read data
   output logic hreadyout_out, // ahb slave ready
   output logic hresp_out // ahb response
);

   localparam int NRELAY = rbcp_pkg::RBCP_RELAYS_PER_BANK * rbcp_pkg::RBCP_NUM_BANKS;
   localparam logic [7:0] YEAR_BYTE = 8'(PROD_YEAR - rbcp_pkg::RBCP_YEAR_BASE);

   function automatic logic in_range(input logic [7:0] c, input logic [7:0] base);
      in_range = (c >= base) && ((c - base) < rbcp_pkg::RBCP_RELAY_SPAN);
   endfunction

   function automatic logic is_select(input logic [7:0] c);
      is_select = (c >= rbcp_pkg::RBCP_CMD_IDENT);
   endfunction

   function automatic logic needs_arg(input logic [7:0] c);
      needs_arg = (c == rbcp_pkg::RBCP_CMD_ENA_SEL) || (c == rbcp_pkg::RBCP_CMD_DIS_SEL) ||
                  (c == rbcp_pkg::RBCP_CMD_ENA_ONLY) || (c == rbcp_pkg::RBCP_CMD_DIS_ONLY) ||
                  (c == rbcp_pkg::RBCP_CMD_DEVNUM_ST) || (c == rbcp_pkg::RBCP_CMD_BANK_SEL) ||
                  in_range(c, rbcp_pkg::RBCP_CMD_OFF_BANK) || in_range(c, rbcp_pkg::RBCP_CMD_ON_BANK);
   endfunction

   function automatic logic bank_ok(input logic [7:0] b);
      bank_ok = (32'(b) <= rbcp_pkg::RBCP_NUM_BANKS);
   endfunction

   // set or clear relay idx in one bank, or in all banks for bank 0
   function automatic logic [NRELAY-1:0] relay_apply(input logic [NRELAY-1:0] img,
                                                    input logic [7:0] bank,
                                                    input logic [2:0] idx,
                                                    input logic on);
      logic [NRELAY-1:0] res;
      res = img;
      for (int b = 0; b < rbcp_pkg::RBCP_NUM_BANKS; b++) begin
         if (bank == rbcp_pkg::RBCP_BANK_ALL || 32'(bank) == b + 1) begin
            res[b * rbcp_pkg::RBCP_RELAYS_PER_BANK + 32'(idx)] = on;
         end
      end
      relay_apply = res;
   endfunction

   rbcp_pkg::rbcp_state_t state;
   rbcp_pkg::rbcp_state_t next_state;
   logic [7:0] cmd;
   logic take;
   logic go;
   logic [7:0] go_cmd;
   logic [7:0] go_arg;
   logic allowed;

   logic enabled;
   logic [7:0] devnum;
   logic config_mode;
   logic cfg_done;
   logic [NUM_SWITCHES-1:0] sw_meta;
   logic [NUM_SWITCHES-1:0] sw_sync;

   logic [7:0] bank;
   logic auto_refresh;
   logic [NRELAY-1:0] image;
   logic relay_cmd;
   logic [7:0] relay_bank;
   logic [2:0] relay_idx;
   logic relay_on;
   logic [NRELAY-1:0] next_image;

   logic report_en;
   logic [3:0][7:0] tx_buf;
   logic [2:0] tx_cnt;
   logic [3:0][7:0] load_buf;
   logic [2:0] load_n;

   logic dp_write;
   logic [7:0] dp_addr;
   logic ap_take;
   logic next_report;
   rbcp_pkg::rbcp_status_t status;

   // byte intake and command framing
   assign take = rx_in.valid && rx_ready_out;

   always_comb begin
      next_state = state;
      go = 1'b0;
      go_cmd = cmd;
      go_arg = rx_in.data;
      unique case (state)
         rbcp_pkg::RBCP_ST_PREFIX: begin
            if (take && rx_in.data == rbcp_pkg::RBCP_PREFIX) begin
               next_state = rbcp_pkg::RBCP_ST_CMD;
            end
         end
         rbcp_pkg::RBCP_ST_CMD: begin
            if (take) begin
               if (needs_arg(rx_in.data)) begin
                  next_state = rbcp_pkg::RBCP_ST_ARG;
               end else begin
                  // unknown codes pass through here and match nothing
                  go = 1'b1;
                  go_cmd = rx_in.data;
                  next_state = rbcp_pkg::RBCP_ST_PREFIX;
               end
            end
         end
         rbcp_pkg::RBCP_ST_ARG: begin
            if (take) begin
               go = 1'b1;
               next_state = rbcp_pkg::RBCP_ST_PREFIX;
            end
         end
         default: next_state = rbcp_pkg::RBCP_ST_PREFIX;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         state <= rbcp_pkg::RBCP_ST_PREFIX;
         cmd <= 8'h00;
      end else begin
         state <= next_state;
         if (take && state == rbcp_pkg::RBCP_ST_CMD) begin
            cmd <= rx_in.data;
         end
      end
   end

   // disabled units still consume arguments so framing stays aligned
   assign allowed = enabled || is_select(go_cmd);

   // option switches are pins; the mode is caught once after reset release
   always_ff @(posedge core_clk_in) begin
      sw_meta <= option_sw_in;
      sw_sync <= sw_meta;
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         config_mode <= 1'b0;
         cfg_done <= 1'b0;
      end else if (!cfg_done) begin
         cfg_done <= 1'b1;
         config_mode <= (sw_sync == '0);
      end
   end

   // device selection and device number
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         enabled <= 1'b1;
         devnum <= DEVNUM_RESET;
      end else if (go) begin
         unique case (go_cmd)
            rbcp_pkg::RBCP_CMD_ENA_ALL: enabled <= 1'b1;
            rbcp_pkg::RBCP_CMD_DIS_ALL: enabled <= 1'b0;
            rbcp_pkg::RBCP_CMD_ENA_SEL: begin
               if (go_arg == devnum) begin
                  enabled <= 1'b1;
               end
            end
            rbcp_pkg::RBCP_CMD_DIS_SEL: begin
               if (go_arg == devnum) begin
                  enabled <= 1'b0;
               end
            end
            rbcp_pkg::RBCP_CMD_ENA_ONLY: enabled <= (go_arg == devnum);
            rbcp_pkg::RBCP_CMD_DIS_ONLY: enabled <= (go_arg != devnum);
            rbcp_pkg::RBCP_CMD_DEVNUM_ST: begin
               if (config_mode) begin
                  devnum <= go_arg;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // relay command decode
   always_comb begin
      relay_cmd = 1'b0;
      relay_bank = bank;
      relay_idx = 3'(go_cmd - rbcp_pkg::RBCP_CMD_OFF_BASE);
      relay_on = 1'b0;
      if (go && allowed) begin
         if (in_range(go_cmd, rbcp_pkg::RBCP_CMD_OFF_BASE)) begin
            relay_cmd = 1'b1;
         end else if (in_range(go_cmd, rbcp_pkg::RBCP_CMD_ON_BASE)) begin
            relay_cmd = 1'b1;
            relay_on = 1'b1;
            relay_idx = 3'(go_cmd - rbcp_pkg::RBCP_CMD_ON_BASE);
         end else if (in_range(go_cmd, rbcp_pkg::RBCP_CMD_OFF_BANK)) begin
            relay_cmd = bank_ok(go_arg);
            relay_bank = go_arg;
            relay_idx = 3'(go_cmd - rbcp_pkg::RBCP_CMD_OFF_BANK);
         end else if (in_range(go_cmd, rbcp_pkg::RBCP_CMD_ON_BANK)) begin
            relay_cmd = bank_ok(go_arg);
            relay_on = 1'b1;
            relay_bank = go_arg;
            relay_idx = 3'(go_cmd - rbcp_pkg::RBCP_CMD_ON_BANK);
         end
      end
      next_image = relay_apply(image, relay_bank, relay_idx, relay_on);
   end

   // bank selection and refresh mode
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         bank <= rbcp_pkg::RBCP_BANK_RESET;
         auto_refresh <= 1'b1;
      end else if (go && allowed) begin
         if (go_cmd == rbcp_pkg::RBCP_CMD_BANK_SEL && bank_ok(go_arg)) begin
            bank <= go_arg;
         end
         if (go_cmd == rbcp_pkg::RBCP_CMD_AUTO_ON) begin
            auto_refresh <= 1'b1;
         end
         if (go_cmd == rbcp_pkg::RBCP_CMD_AUTO_OFF) begin
            auto_refresh <= 1'b0;
         end
      end
   end

   // image memory and outputs; auto mode also flushes earlier pending changes
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         image <= '0;
         relay_out <= '0;
      end else begin
         if (relay_cmd) begin
            image <= next_image;
            if (auto_refresh) begin
               relay_out <= next_image;
            end
         end else if (go && allowed && go_cmd == rbcp_pkg::RBCP_CMD_REFRESH) begin
            relay_out <= image;
         end
      end
   end

   // reply assembly
   always_comb begin
      load_buf = '0;
      load_n = 3'h0;
      if (go && go_cmd == rbcp_pkg::RBCP_CMD_IDENT) begin
         load_buf = {YEAR_BYTE, FW_VERSION, ID_PART2, ID_PART1};
         load_n = 3'h4;
      end else if (go && go_cmd == rbcp_pkg::RBCP_CMD_DEVNUM_RD) begin
         load_buf[0] = devnum;
         load_n = 3'h1;
      end else if (go && allowed && report_en && !is_select(go_cmd) &&
                   (relay_cmd || go_cmd == rbcp_pkg::RBCP_CMD_BANK_SEL ||
                    go_cmd == rbcp_pkg::RBCP_CMD_AUTO_ON || go_cmd == rbcp_pkg::RBCP_CMD_AUTO_OFF ||
                    go_cmd == rbcp_pkg::RBCP_CMD_REFRESH)) begin
         load_buf[0] = rbcp_pkg::RBCP_ACK;
         load_n = 3'h1;
      end
   end

   // reply shifter; intake stalls until every reply byte has left
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         tx_buf <= '0;
         tx_cnt <= 3'h0;
         tx_out <= '0;
         rx_ready_out <= 1'b0;
      end else begin
         if (load_n != 3'h0) begin
            tx_buf <= load_buf;
            tx_cnt <= load_n;
         end else if (tx_cnt != 3'h0 && (!tx_out.valid || tx_ready_in)) begin
            tx_out.valid <= 1'b1;
            tx_out.data <= tx_buf[0];
            tx_buf <= {8'h00, tx_buf[3:1]};
            tx_cnt <= tx_cnt - 3'h1;
         end else if (tx_out.valid && tx_ready_in) begin
            tx_out.valid <= 1'b0;
         end
         rx_ready_out <= (load_n == 3'h0) && (tx_cnt == 3'h0) && (!tx_out.valid || tx_ready_in);
      end
   end

   // ahb-lite slave, zero wait states, always okay
   assign ap_take = hsel_in && htrans_in[1] && hready_in;
   assign next_report = (dp_write && dp_addr == rbcp_pkg::RBCP_REG_CTRL) ?
                        hwdata_in[rbcp_pkg::RBCP_CTRL_REPORT_BIT] : report_en;

   always_comb begin
      status.enabled = enabled;
      status.config_mode = config_mode;
      status.auto_refresh = auto_refresh;
      status.bank = bank;
      status.devnum = devnum;
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_write <= ap_take && hwrite_in;
         if (ap_take) begin
            dp_addr <= haddr_in[7:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         report_en <= rbcp_pkg::RBCP_CTRL_REPORT_RST;
      end else begin
         report_en <= next_report;
      end
   end

   // read data is sampled in the address phase; ctrl is forwarded from a write in flight
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         hrdata_out <= 32'h0000_0000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else if (ap_take && !hwrite_in && haddr_in[31:8] == 24'h00_0000) begin
         unique case (haddr_in[7:0])
            rbcp_pkg::RBCP_REG_CTRL: hrdata_out <= {31'h0000_0000, next_report};
            rbcp_pkg::RBCP_REG_STATUS: hrdata_out <= {13'h0000, status};
            rbcp_pkg::RBCP_REG_IDENT: hrdata_out <= {YEAR_BYTE, FW_VERSION, ID_PART2, ID_PART1};
            default: hrdata_out <= 32'h0000_0000;
         endcase
      end else if (ap_take) begin
         hrdata_out <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// file: rbcp_parser_bench.sv
// self-checking bench for the relay bank command parser
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module rbcp_parser_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] P = 8'hFE;
   localparam logic [7:0] A = rbcp_pkg::RBCP_ACK;
   localparam logic [7:0] ID1 = 8'h3C; // arbitrary value
   localparam logic [7:0] ID2 = 8'hC3; // arbitrary value
   localparam logic [7:0] FW = 8'h11;
   localparam int YEAR = 2011;
   logic clk, nrst, rdy, hrdy, hsel, hwrite, hresp, slow, txr;
   logic [7:0] sw;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [255:0] relay, er;
   rbcp_pkg::rbcp_byte_t rx, tx;
   int n_mismatch, check_count;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   rbcp_parser #(.ID_PART1(ID1), .ID_PART2(ID2), .FW_VERSION(FW), .PROD_YEAR(YEAR)) rbcp_parser_inst (
      .core_clk_in(clk), .nrst_in(nrst), .option_sw_in(sw), .rx_in(rx), .tx_out(tx), .tx_ready_in(txr),
      .rx_ready_out(rdy), .relay_out(relay), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
      .hreadyout_out(hrdy), .hresp_out(hresp));
   rbcp_host rbcp_host_inst (.clk_in(clk), .nrst_in(nrst), .slow_in(slow), .tx_in(tx), .ready_out(txr));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ready is registered, so the level at the falling edge is what the next rising edge samples
   task automatic wt(ref logic s);
      for (int i = 0; i < 500; i++) begin
         @(negedge clk);
         if (s === 1'b1) break;
      end
      if (s !== 1'b1) begin
         n_mismatch++;
         end_sim();
      end
      @(posedge clk);
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt(hrdy);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt(hrdy);
      r = hrdata;
   endtask
   task automatic st(input logic [31:0] e);
      ahb(1'b0, 32'h4, 32'h0);
      `CHK(r, e)
   endtask
   // send bytes back to back, then expect exactly the given reply
   task automatic x(input logic [7:0] c[$], input logic [7:0] e[$]);
      rbcp_host_inst.got.delete();
      foreach (c[k]) begin
         rx.valid <= 1'b1;
         rx.data <= c[k];
         wt(rdy);
      end
      rx.valid <= 1'b0;
      for (int i = 0; i < 300 && rbcp_host_inst.got.size() < e.size(); i++) @(posedge clk);
      repeat (8) @(posedge clk);
      `CHK(rbcp_host_inst.got.size(), e.size())
      foreach (e[k]) `CHK(rbcp_host_inst.got[k], e[k])
   endtask
   task automatic t_reset();
      `CHK(relay, 256'h0)
      `CHK({hresp, hrdy}, 2'b01)
      st(32'h0007_0100);
      ahb(1'b0, 32'h8, 32'h0);
      `CHK(r, {8'(YEAR - 1800), FW, ID2, ID1})
      ahb(1'b0, 32'h40, 32'h0);
      `CHK(r, 32'h0)
      $display("test reset done");
   endtask
   task automatic t_bank();
      x('{P, 8'h08}, '{A});
      er[0] = 1'b1;
      `CHK(relay, er)
      x('{P, 8'h31, 8'h03}, '{A});
      x('{P, 8'h0A}, '{A});
      er[18] = 1'b1;
      `CHK(relay, er)
      x('{P, 8'h70, 8'h05}, '{A});
      x('{P, 8'h08}, '{A});
      er[36] = 1'b1;
      er[16] = 1'b1;
      `CHK(relay, er)
      x('{P, 8'h6C, 8'h21}, '{});
      x('{P, 8'h31, 8'h00}, '{A});
      x('{P, 8'h0F}, '{A});
      for (int b = 0; b < 32; b++) er[b * 8 + 7] = 1'b1;
      `CHK(relay, er)
      x('{P, 8'h31, 8'h01}, '{A});
      $display("test bank done");
   endtask
   task automatic t_refresh();
      x('{P, 8'h1A}, '{A});
      x('{P, 8'h00}, '{A});
      x('{P, 8'h6C, 8'h20}, '{A});
      `CHK(relay, er)
      er[0] = 1'b0;
      er[248] = 1'b1;
      x('{P, 8'h25}, '{A});
      `CHK(relay, er)
      x('{P, 8'h19}, '{A});
      $display("test refresh done");
   endtask
   task automatic t_select();
      logic [7:0] tc[10] = '{8'hF9, 8'hF8, 8'hFB, 8'hFA, 8'hFA, 8'hFB, 8'hFC, 8'hFC, 8'hFD, 8'hFD};
      logic [7:0] ta[10] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h05};
      logic [9:0] te = 10'b1010110010;
      for (int i = 0; i < 10; i++) begin
         if (tc[i] > 8'hF9) x('{P, tc[i], ta[i]}, '{});
         else x('{P, tc[i]}, '{});
         st({13'h0, te[i], 2'b11, 8'h01, 8'h00});
         if (te[i]) x('{P, 8'h25}, '{A});
         else x('{P, 8'h25}, '{});
      end
      $display("test select done");
   endtask
   task automatic t_ident();
      slow <= 1'b1;
      x('{P, 8'hF6}, '{ID1, ID2, FW, 8'(YEAR - 1800)});
      slow <= 1'b0;
      x('{P, 8'hFF, 8'h07}, '{});
      x('{P, 8'hF7}, '{8'h07});
      st(32'h0007_0107);
      ahb(1'b1, 32'h0, 32'h0);
      x('{P, 8'h25}, '{});
      ahb(1'b1, 32'h0, 32'h1);
      x('{8'h08}, '{});
      `CHK(relay, er)
      x('{P, 8'hF0}, '{});
      x('{P, 8'h25}, '{A});
      $display("test ident done");
   endtask
   task automatic t_normal();
      sw <= 8'h01;
      repeat (3) @(posedge clk);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      st(32'h0005_0100);
      x('{P, 8'hFF, 8'h09}, '{});
      x('{P, 8'hF7}, '{8'h00});
      $display("test normal mode done");
   endtask
   initial begin
      nrst = 1'b0;
      sw = 8'h00;
      rx = '0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      slow = 1'b0;
      er = '0;
      n_mismatch = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      // config mode is latched at the first edge after release, so status waits one edge
      @(posedge clk);
      t_reset();
      t_bank();
      t_refresh();
      t_select();
      t_ident();
      t_normal();
      end_sim();
   end
endmodule
`default_nettype wire

// file: rbcp_pkg.sv
// shared constants and types for the relay bank command parser
`default_nettype none

package rbcp_pkg;

   // framing and acknowledge bytes
   localparam logic [7:0] RBCP_PREFIX = 8'hFE;
   localparam logic [7:0] RBCP_ACK = 8'h55;

   // device selection commands
   localparam logic [7:0] RBCP_CMD_IDENT = 8'hF6;
   localparam logic [7:0] RBCP_CMD_DEVNUM_RD = 8'hF7;
   localparam logic [7:0] RBCP_CMD_ENA_ALL = 8'hF8;
   localparam logic [7:0] RBCP_CMD_DIS_ALL = 8'hF9;
   localparam logic [7:0] RBCP_CMD_ENA_SEL = 8'hFA;
   localparam logic [7:0] RBCP_CMD_DIS_SEL = 8'hFB;
   localparam logic [7:0] RBCP_CMD_ENA_ONLY = 8'hFC;
   localparam logic [7:0] RBCP_CMD_DIS_ONLY = 8'hFD;
   localparam logic [7:0] RBCP_CMD_DEVNUM_ST = 8'hFF;

   // relay and refresh commands
   localparam logic [7:0] RBCP_CMD_OFF_BASE = 8'h00;
   localparam logic [7:0] RBCP_CMD_ON_BASE = 8'h08;
   localparam logic [7:0] RBCP_CMD_BANK_SEL = 8'h31;
   localparam logic [7:0] RBCP_CMD_OFF_BANK = 8'h64;
   localparam logic [7:0] RBCP_CMD_ON_BANK = 8'h6C;
   localparam logic [7:0] RBCP_CMD_AUTO_ON = 8'h19;
   localparam logic [7:0] RBCP_CMD_AUTO_OFF = 8'h1A;
   localparam logic [7:0] RBCP_CMD_REFRESH = 8'h25;
   localparam logic [7:0] RBCP_RELAY_SPAN = 8'h08;

   // relay organisation
   localparam int RBCP_RELAYS_PER_BANK = 8;
   localparam int RBCP_NUM_BANKS = 32;
   localparam logic [7:0] RBCP_BANK_ALL = 8'h00;
   localparam logic [7:0] RBCP_BANK_RESET = 8'h01;
   localparam int RBCP_YEAR_BASE = 1800;

   // register byte offsets and fields
   localparam logic [7:0] RBCP_REG_CTRL = 8'h00;
   localparam logic [7:0] RBCP_REG_STATUS = 8'h04;
   localparam logic [7:0] RBCP_REG_IDENT = 8'h08;
   localparam int RBCP_CTRL_REPORT_BIT = 0;
   localparam logic RBCP_CTRL_REPORT_RST = 1'b1;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rbcp_byte_t;

   // readback layout of the status register, low bits first from devnum
   typedef struct packed {
      logic enabled;
      logic config_mode;
      logic auto_refresh;
      logic [7:0] bank;
      logic [7:0] devnum;
   } rbcp_status_t;

   typedef enum logic [2:0] {
      RBCP_ST_PREFIX = 3'b001,
      RBCP_ST_CMD = 3'b010,
      RBCP_ST_ARG = 3'b100
   } rbcp_state_t;

endpackage

`default_nettype wire

// file: rbcp_props.sv
// assertion checker for the relay bank command parser ports
`default_nettype none
module rbcp_props #(
   parameter logic [7:0] ID_PART1 = 8'h00
) (
   input wire logic core_clk_in, // clock
   input wire logic nrst_in, // reset, active low
   input wire rbcp_pkg::rbcp_byte_t rx_in, // received bytes
   input wire logic rx_ready_out, // parser takes a byte
   input wire rbcp_pkg::rbcp_byte_t tx_out, // reply bytes
   input wire logic tx_ready_in, // sink takes a byte
   input wire logic [255:0] relay_out // relay drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tk;
   logic [1:0] stg;
   logic [7:0] code;
   assign tk = rx_in.valid && rx_ready_out;
   // mirror of the framing, so a code byte is told apart from an argument byte
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         stg <= 2'h0;
         code <= 8'h00;
      end else if (tk) begin
         code <= rx_in.data;
         case (stg)
            2'h0: stg <= (rx_in.data == 8'hFE) ? 2'h1 : 2'h0;
            2'h1: stg <= (rx_in.data inside {[8'hFA:8'hFD], 8'hFF, 8'h31, [8'h64:8'h73]}) ? 2'h2 : 2'h0;
            default: stg <= 2'h0;
         endcase
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   AST_TX_HOLD: assert property (tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out.data))
      else $error("reply byte changed before taken");
   AST_TX_BLOCKS_RX: assert property (tx_out.valid |-> !rx_ready_out)
      else $error("byte taken while replying");
   AST_RST_STATE: assert property ($rose(nrst_in) |-> relay_out == 256'h0 && !tx_out.valid && !rx_ready_out)
      else $error("bad state after reset");
   AST_SEL_NO_ACK: assert property (tk && stg == 2'h1 && rx_in.data inside {8'hF8, 8'hF9} |=> !tx_out.valid [*3])
      else $error("reply after select all");
   AST_SEL_ARG_NO_ACK: assert property (tk && stg == 2'h2 && code inside {[8'hFA:8'hFD]} |=> !tx_out.valid [*3])
      else $error("reply after unit select");
   AST_UNKNOWN_DROP: assert property (tk && stg == 2'h1 && rx_in.data == 8'hF0 |=> !tx_out.valid [*3] ##1 rx_ready_out)
      else $error("unknown code not dropped");
   AST_IDENT_FIRST: assert property (tk && stg == 2'h1 && rx_in.data == 8'hF6 |-> ##[1:4] (tx_out.valid && tx_out.data == ID_PART1))
      else $error("identity reply missing");
   AST_RELAY_CAUSE: assert property (!$stable(relay_out) |-> $past(tk) || $past(tk, 2))
      else $error("relays moved without a command");
endmodule
bind rbcp_parser rbcp_props #(.ID_PART1(ID_PART1)) rbcp_props_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
   .rx_in(rx_in), .rx_ready_out(rx_ready_out), .tx_out(tx_out), .tx_ready_in(tx_ready_in), .relay_out(relay_out));
`default_nettype wire
